// ===== tb_usart_clock_frame_transmitter.sv
`timescale 1ns/1ns
`default_nettype none
module tb_usart_clock_frame_transmitter
    import uct_pkg::*;
;
    logic ref_clk, rst_b, slave, dbl, inv, pha, ord, two, ten, onew, twr, tclr, rxp, rxv, xck_in;
    logic [1:0] comm, par;
    logic [2:0] csz;
    logic [15:0] baud;
    logic [8:0] tbuf, rxd;
    logic txd, txd_oe_b, sh_oe_b, xck_out, xck_oe_b, empty, cmpl, strobe, perr;
    logic clocked, srise, srun, pclr, line;
    logic [7:0] bclk;
    logic [4:0] flen, pcount;
    logic [31:0] pbits;
    int errors, tests_run, cycles, strobes;
    assign line = slave ? xck_in : xck_out;
    uct_usart_tx i_uct_usart_tx (.REF_CLK(ref_clk), .RST_B(rst_b), .COMMUNICATION_SELECT(comm),
        .SYNC_SLAVE_SELECT(slave), .DOUBLE_SPEED_SETTING(dbl), .PIN_INVERSION_ENABLE(inv),
        .SPI_CLOCK_PHASE(pha), .SPI_BIT_ORDER(ord), .PARITY_SELECT(par), .CHAR_SIZE_SELECT(csz),
        .TWO_STOP_BITS(two), .BAUD_SETTING(baud), .TX_ENABLE(ten), .ONE_WIRE_MODE(onew),
        .TRANSMIT_BUFFER(tbuf), .TRANSMIT_BUFFER_WRITE(twr), .TRANSMIT_COMPLETE_CLEAR(tclr),
        .TRANSFER_CLOCK_PIN_IN(xck_in), .RX_CHECK_DATA(rxd), .RX_CHECK_PARITY(rxp), .RX_CHECK_VALID(rxv),
        .TXD_OUT(txd), .TXD_OE_B(txd_oe_b), .SHARED_DATA_OE_B(sh_oe_b), .TRANSFER_CLOCK_PIN_OUT(xck_out),
        .TRANSFER_CLOCK_PIN_OE_B(xck_oe_b), .BUFFER_EMPTY_FLAG(empty), .TRANSMIT_COMPLETE_FLAG(cmpl),
        .RX_SAMPLE_STROBE(strobe), .PARITY_ERROR_FLAG(perr));
    uct_peer_model i_uct_peer_model (.ref_clk(ref_clk), .rst_b(rst_b), .clocked(clocked),
        .sample_rise(srise), .slave_run(srun), .bit_clocks(bclk), .frame_len(flen), .clear(pclr),
        .txd_out(txd), .clock_line(line), .slave_clock(xck_in), .bits(pbits), .count(pcount));
    // ****************************************
    // helpers
    // ****************************************
    task automatic stop_test;
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // caller only writes while the empty flag is up
    task automatic write_buf(input logic [8:0] d);
        @(posedge ref_clk);
        tbuf <= d;
        twr <= 1'b1;
        @(posedge ref_clk);
        twr <= 1'b0;
    endtask
    task automatic prep;
        @(posedge ref_clk);
        tclr <= 1'b1;
        pclr <= 1'b1;
        @(posedge ref_clk);
        tclr <= 1'b0;
        pclr <= 1'b0;
    endtask
    task automatic wait_cmpl;
        int i;
        for (i = 0; i < 3000 && cmpl !== 1'b1; i++) tick(1);
        check(cmpl, 1'b1);
    endtask
    function automatic logic [31:0] frame(input logic [8:0] d, input int n, input logic [1:0] p, input logic t);
        logic [31:0] f;
        int k;
        f = '1;
        f[0] = 1'b0;
        for (k = 0; k < n; k++) f[k + 1] = d[k];
        if (p[1]) f[n + 1] = (^(d & ((9'h1 << n) - 9'h1))) ^ p[0];
        return f;
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic async_frames;
        int k, n, len;
        logic [1:0] p;
        logic [8:0] d;
        logic [31:0] m;
        for (k = 0; k < 5; k++) begin
            n = k + 5;
            d = 9'h1A6 ^ 9'(k * 37);
            p = (k % 3 == 0) ? UCT_PAR_NONE : (k % 3 == 1) ? UCT_PAR_EVEN : UCT_PAR_ODD;
            len = 2 + n + p[1] + k[0];
            m = (32'h1 << len) - 32'h1;
            @(posedge ref_clk);
            comm <= UCT_COMM_ASYNC;
            csz <= 3'(k);
            par <= p;
            two <= k[0];
            dbl <= k[1];
            bclk <= k[1] ? 8'h08 : 8'h10;
            clocked <= 1'b0;
            flen <= 5'(len);
            prep();
            write_buf(d);
            wait_cmpl();
            check(pbits & m, frame(d, n, p, k[0]) & m);
            check(pcount, len);
            check(txd, 1'b1);
        end
    endtask
    task automatic back_to_back;
        @(posedge ref_clk);
        csz <= 3'h3;
        par <= UCT_PAR_NONE;
        two <= 1'b0;
        dbl <= 1'b0;
        bclk <= 8'h10;
        flen <= 5'd10;
        prep();
        write_buf(9'h05A);
        tick(4);
        check(empty, 1'b1);
        write_buf(9'h0C3);
        tick(20);
        check(empty, 1'b0);
        check(cmpl, 1'b0);
        wait_cmpl();
        check(pbits & 32'h000F_FFFF, (frame(9'h05A, 8, 2'b00, 1'b0) & 32'h3FF) |
            ((frame(9'h0C3, 8, 2'b00, 1'b0) & 32'h3FF) << 10));
    endtask
    task automatic spi_modes;
        int k;
        logic [7:0] e;
        for (k = 0; k < 4; k++) begin
            // settings only change between transfers
            @(posedge ref_clk);
            comm <= UCT_COMM_SPI;
            inv <= k[1];
            pha <= k[0];
            ord <= k[1] ^ k[0];
            baud <= 16'h0100;
            clocked <= 1'b1;
            srise <= k[1] == k[0];
            tick(3);
            strobes = 0;
            prep();
            write_buf(9'h0B4);
            wait_cmpl();
            tick(4);
            e = (k[1] ^ k[0]) ? 8'hB4 : 8'h2D;
            check(pcount, 5'd8);
            check(strobes, 8);
            check(pbits[7:0], e);
            check(xck_out, k[1]);
            check(xck_oe_b, 1'b0);
        end
    endtask
    task automatic sync_slave;
        int i;
        @(posedge ref_clk);
        comm <= UCT_COMM_SYNC;
        par <= UCT_PAR_NONE;
        slave <= 1'b1;
        inv <= 1'b0;
        pha <= 1'b1;
        ord <= 1'b1;
        srise <= 1'b0;
        tick(3);
        prep();
        check(xck_oe_b, 1'b1);
        write_buf(9'h069);
        tick(3);
        srun <= 1'b1;
        for (i = 0; i < 2000 && pcount < 5'd10; i++) tick(1);
        srun <= 1'b0;
        check(pbits & 32'h3FF, frame(9'h069, 8, 2'b00, 1'b0) & 32'h3FF);
        tick(20);
        @(posedge ref_clk);
        slave <= 1'b0;
        tick(2);
        check(xck_oe_b, 1'b0);
    endtask
    task automatic parity_try(input logic [1:0] p, input logic b, input logic exp);
        @(posedge ref_clk);
        par <= p;
        rxd <= 9'h003;
        rxp <= b;
        rxv <= 1'b1;
        @(posedge ref_clk);
        rxv <= 1'b0;
        tick(1);
        check(perr, exp);
    endtask
    task automatic pin_owner;
        tick(1);
        check(txd_oe_b, 1'b0);
        check(sh_oe_b, 1'b1);
        @(posedge ref_clk);
        onew <= 1'b1;
        tick(1);
        check(sh_oe_b, 1'b0);
        @(posedge ref_clk);
        onew <= 1'b0;
        ten <= 1'b0;
        tick(1);
        check(txd_oe_b, 1'b1);
        @(posedge ref_clk);
        ten <= 1'b1;
    endtask
    // ****************************************
    // run
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (strobe === 1'b1) strobes++;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        {rst_b, slave, dbl, inv, pha, ord, two, onew, twr, tclr, rxp, rxv, srun, pclr, clocked, srise} <= '0;
        ten <= 1'b1;
        comm <= UCT_COMM_ASYNC;
        par <= UCT_PAR_NONE;
        csz <= 3'h3;
        baud <= 16'h0040;
        tbuf <= 9'h000;
        rxd <= 9'h000;
        bclk <= 8'h10;
        flen <= 5'd10;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(1);
        check({txd, empty, cmpl, perr}, 4'b1100);
        pin_owner();
        async_frames();
        back_to_back();
        parity_try(UCT_PAR_EVEN, 1'b1, 1'b1);
        parity_try(UCT_PAR_EVEN, 1'b0, 1'b0);
        parity_try(UCT_PAR_ODD, 1'b1, 1'b0);
        spi_modes();
        sync_slave();
        stop_test();
    end
endmodule
`default_nettype wire

// ===== uct_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "uct_params.svh"
module uct_baud_gen (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [15:0] divisor,
    output logic tick
);
    logic [16:0] acc;
    logic [16:0] next_acc;
    logic next_tick;
    logic [16:0] sum;
    logic [16:0] lim;

    // fractional accumulator: one tick per divisor/64 clocks
    always_comb begin
        sum = acc + `UCT_FRAC_STEP;
        // divisors below one whole clock would overrun, so clamp
        lim = {1'b0, (divisor < `UCT_MIN_DIVISOR) ? `UCT_MIN_DIVISOR : divisor};
        next_acc = 17'h0_0000;
        next_tick = 1'b0;
        if (run) begin
            if (sum >= lim) begin
                next_acc = sum - lim;
                next_tick = 1'b1;
            end else begin
                next_acc = sum;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= 17'h0_0000;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end

    // integer-only divisor of at least two clocks never ticks twice in a row
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_b)
        (run && divisor[5:0] == 6'h00 && divisor[15:6] > 10'h001 && tick) |=> !tick)
        else $error("baud tick repeated too soon");
endmodule
`default_nettype wire

// ===== uct_params.svh
`ifndef UCT_PARAMS_SVH
`define UCT_PARAMS_SVH
// *****************************************
// timing and framing constants
// *****************************************
`define UCT_FRAC_STEP 17'h0_0040
`define UCT_MIN_DIVISOR 16'h0040
`define UCT_LAST_SAMPLE_NORMAL 4'hF
`define UCT_LAST_SAMPLE_DOUBLE 4'h7
`define UCT_SPI_LAST_BIT 4'h7
`define UCT_CHAR_BASE 4'h5
`define UCT_CHAR_MAX_CODE 3'h4
`define UCT_START_LEVEL 1'b0
`define UCT_STOP_LEVEL 1'b1
`define UCT_IDLE_LEVEL 1'b1
// *****************************************
// reset values
// *****************************************
`define UCT_RST_BUFFER_EMPTY 1'b1
`define UCT_RST_TX_COMPLETE 1'b0
`define UCT_RST_CLOCK_LEVEL 1'b0
`endif

// ===== uct_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module uct_peer_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clocked,
    input wire logic sample_rise,
    input wire logic slave_run,
    input wire logic [7:0] bit_clocks,
    input wire logic [4:0] frame_len,
    input wire logic clear,
    input wire logic txd_out,
    input wire logic clock_line,
    output logic slave_clock,
    output logic [31:0] bits,
    output logic [4:0] count
);
    logic busy, prev;
    logic txd_prev;
    logic [7:0] tick;
    logic [4:0] left;
    logic [1:0] div;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            prev <= 1'b0;
            txd_prev <= 1'b1;
            count <= 5'h0;
            div <= 2'h0;
            slave_clock <= 1'b0;
        end else begin
            prev <= clock_line;
            txd_prev <= txd_out;
            div <= div + 2'h1;
            // phases of four core clocks, twice the least that is seen reliably
            if (div == 2'h3) begin
                slave_clock <= slave_run ? ~slave_clock : 1'b0;
            end
            if (clear) begin
                count <= 5'h0;
                busy <= 1'b0;
            end else if (clocked) begin
                // edge is seen one clock late: take the data that stood at the edge
                if (clock_line != prev && clock_line == sample_rise) begin
                    bits[count] <= txd_prev;
                    count <= count + 5'h1;
                end
            end else if (!busy) begin
                if (!txd_out) begin
                    busy <= 1'b1;
                    tick <= bit_clocks >> 1;
                    left <= frame_len;
                end
            end else if (tick != 8'h0) begin
                tick <= tick - 8'h1;
            end else begin
                bits[count] <= txd_out;
                count <= count + 5'h1;
                tick <= bit_clocks - 8'h1;
                left <= left - 5'h1;
                busy <= left != 5'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== uct_pkg.sv
package uct_pkg;
    typedef enum logic {
        UCT_IDLE = 1'b0,
        UCT_ACTIVE = 1'b1
    } uct_state_t;
    typedef enum logic [1:0] {
        UCT_COMM_ASYNC = 2'b00,
        UCT_COMM_SYNC = 2'b01,
        UCT_COMM_SPI = 2'b11
    } uct_comm_t;
    typedef enum logic [1:0] {
        UCT_PAR_NONE = 2'b00,
        UCT_PAR_EVEN = 2'b10,
        UCT_PAR_ODD = 2'b11
    } uct_parity_t;
endpackage

// ===== uct_usart_tx.sv
// Functional notes
// - double speed doubles baud rate using 8 samples per bit, not 16.
// - sync mode: clock pin drives in master, is input in slave.
// - sync sampling happens on the edge opposite the data change edge.
// - inversion off: change rising, sample falling; inversion on swaps them.
// - master SPI uses the internal baud generator like sync master.
// - SPI modes picked by inversion and phase; phase chooses leading sample or setup.
// - any frame of start, 5..9 data, optional parity, 1 or 2 stops.
// - start bit low, stop bits high, idle line high.
// - even parity bit is one for odd ones count; odd parity the reverse.
// - received data parity is checked and a mismatch raises an error flag.
// - SPI frames carry exactly eight bits, MSB or LSB first.
// - after a frame, next pending frame follows at once, else line idles high.
// - enabled transmitter owns data pin; one-wire also drives the shared pin.
// - buffer write starts sending; buffer loads shifter when idle or after last stop.
// - complete flag sets when shifter empties with nothing buffered.
// - async uses 16 or 8 samples per bit; sync uses 2.
// - divider is 10 integer and 6 fraction bits; sync uses integer only.
`timescale 1ns/1ns
`default_nettype none
`include "uct_params.svh"
module uct_usart_tx
    import uct_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [1:0] COMMUNICATION_SELECT,
    input wire logic SYNC_SLAVE_SELECT,
    input wire logic DOUBLE_SPEED_SETTING,
    input wire logic PIN_INVERSION_ENABLE,
    input wire logic SPI_CLOCK_PHASE,
    input wire logic SPI_BIT_ORDER,
    input wire logic [1:0] PARITY_SELECT,
    input wire logic [2:0] CHAR_SIZE_SELECT,
    input wire logic TWO_STOP_BITS,
    input wire logic [15:0] BAUD_SETTING,
    input wire logic TX_ENABLE,
    input wire logic ONE_WIRE_MODE,
    input wire logic [8:0] TRANSMIT_BUFFER,
    input wire logic TRANSMIT_BUFFER_WRITE,
    input wire logic TRANSMIT_COMPLETE_CLEAR,
    input wire logic TRANSFER_CLOCK_PIN_IN,
    input wire logic [8:0] RX_CHECK_DATA,
    input wire logic RX_CHECK_PARITY,
    input wire logic RX_CHECK_VALID,
    output logic TXD_OUT,
    output logic TXD_OE_B,
    output logic SHARED_DATA_OE_B,
    output logic TRANSFER_CLOCK_PIN_OUT,
    output logic TRANSFER_CLOCK_PIN_OE_B,
    output logic BUFFER_EMPTY_FLAG,
    output logic TRANSMIT_COMPLETE_FLAG,
    output logic RX_SAMPLE_STROBE,
    output logic PARITY_ERROR_FLAG
);
    // ****************************************
    // registered state
    // ****************************************
    uct_state_t state, next_state;
    logic [12:0] frame, next_frame;
    logic [3:0] idx, next_idx;
    logic [3:0] last, next_last;
    logic [3:0] smp, next_smp;
    logic primed, next_primed;
    logic level, next_level;
    logic clk_prev, next_clk_prev;
    logic [8:0] buf_data, next_buf_data;
    logic buf_full, next_buf_full;
    logic next_dre, next_txc, next_txd, next_xck, next_strobe, next_perr;

    logic tick, is_async, is_spi, is_slave, lead_setup, par_en, par_bit, load, finish;
    logic lead, trail, change, sample, bit_end, s_lvl, owned;
    logic [3:0] nbits_data, smp_last, pos;
    logic [12:0] built;
    logic [15:0] divisor;
    logic [8:0] rx_masked;

    // ****************************************
    // baud generation
    // ****************************************
    assign is_async = COMMUNICATION_SELECT == UCT_COMM_ASYNC;
    assign is_spi = COMMUNICATION_SELECT == UCT_COMM_SPI;
    assign is_slave = (COMMUNICATION_SELECT == UCT_COMM_SYNC) && SYNC_SLAVE_SELECT;
    // fraction dropped in sync modes; master SPI shares the sync master path
    assign divisor = is_async ? BAUD_SETTING : {BAUD_SETTING[15:6], 6'h00};
    assign smp_last = DOUBLE_SPEED_SETTING ? `UCT_LAST_SAMPLE_DOUBLE : `UCT_LAST_SAMPLE_NORMAL;

    uct_baud_gen u_baud (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .run(state == UCT_ACTIVE && !is_slave),
        .divisor(divisor),
        .tick(tick)
    );

    // ****************************************
    // clock edges and pin ownership
    // ****************************************
    // sync and SPI-phase-1 change data on leading edge, SPI phase 0 on trailing
    assign lead_setup = !is_spi || SPI_CLOCK_PHASE;
    assign s_lvl = TRANSFER_CLOCK_PIN_IN ^ PIN_INVERSION_ENABLE;
    assign lead = state == UCT_ACTIVE && !is_async &&
        (is_slave ? (s_lvl && !clk_prev) : (tick && !level));
    assign trail = state == UCT_ACTIVE && !is_async &&
        (is_slave ? (!s_lvl && clk_prev) : (tick && level));
    assign change = lead_setup ? lead : trail;
    assign sample = lead_setup ? trail : lead;
    assign bit_end = state == UCT_ACTIVE && is_async && tick && smp == smp_last;
    assign finish = is_async ? (bit_end && idx == last) : (trail && primed && idx == last);
    assign load = buf_full && (state == UCT_IDLE || finish);

    // disabling waits for pending data to drain before releasing the pin
    assign owned = TX_ENABLE || state == UCT_ACTIVE || buf_full;
    assign TXD_OE_B = !owned;
    assign SHARED_DATA_OE_B = !(owned && ONE_WIRE_MODE);
    assign TRANSFER_CLOCK_PIN_OE_B = is_async || is_slave;

    // ****************************************
    // frame assembly and next state
    // ****************************************
    always_comb begin
        nbits_data = (CHAR_SIZE_SELECT > `UCT_CHAR_MAX_CODE) ? 4'h9 : ({1'b0, CHAR_SIZE_SELECT} + `UCT_CHAR_BASE);
        par_en = PARITY_SELECT[1];
        par_bit = PARITY_SELECT[0];
        rx_masked = 9'h000;
        built = {13{`UCT_STOP_LEVEL}};
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nbits_data) begin
                par_bit = par_bit ^ buf_data[i];
                rx_masked[i] = RX_CHECK_DATA[i];
            end
        end
        if (is_spi) begin
            for (int i = 0; i < 8; i++) begin
                built[i] = SPI_BIT_ORDER ? buf_data[i] : buf_data[7 - i];
            end
            pos = `UCT_SPI_LAST_BIT;
        end else begin
            built[0] = `UCT_START_LEVEL;
            for (int i = 0; i < 9; i++) begin
                if (4'(i) < nbits_data) begin
                    built[i + 1] = buf_data[i];
                end
            end
            pos = nbits_data + 4'h1;
            if (par_en) begin
                built[pos] = par_bit;
                pos = pos + 4'h1;
            end
            pos = pos + {3'h0, TWO_STOP_BITS};
        end

        next_state = state;
        next_frame = frame;
        next_idx = idx;
        next_last = last;
        next_smp = smp;
        next_primed = primed;
        next_level = level;
        next_clk_prev = s_lvl;
        next_buf_data = buf_data;
        next_buf_full = buf_full;
        next_dre = BUFFER_EMPTY_FLAG;
        next_txc = TRANSMIT_COMPLETE_FLAG;
        next_strobe = sample || (state == UCT_ACTIVE && is_async && tick && smp == (smp_last >> 1));
        next_perr = PARITY_ERROR_FLAG;

        if (state == UCT_ACTIVE && is_async && tick) begin
            next_smp = (smp == smp_last) ? 4'h0 : smp + 4'h1;
        end
        if (state == UCT_ACTIVE && !is_async && !is_slave && tick) begin
            next_level = !level;
        end
        if (bit_end && !finish) begin
            next_idx = idx + 4'h1;
        end
        if (change && !finish) begin
            if (!primed) begin
                next_primed = 1'b1;
            end else begin
                next_idx = idx + 4'h1;
            end
        end
        if (finish) begin
            next_state = UCT_IDLE;
            next_level = `UCT_RST_CLOCK_LEVEL;
            if (!buf_full) begin
                next_txc = 1'b1;
            end
        end
        if (load) begin
            next_state = UCT_ACTIVE;
            next_frame = built;
            next_last = pos;
            next_idx = 4'h0;
            next_smp = 4'h0;
            next_primed = is_async || !lead_setup;
            next_buf_full = 1'b0;
            next_dre = 1'b1;
        end
        if (TRANSMIT_COMPLETE_CLEAR && !(finish && !buf_full)) begin
            next_txc = 1'b0;
        end
        if (TRANSMIT_BUFFER_WRITE) begin
            next_buf_data = TRANSMIT_BUFFER;
            next_buf_full = 1'b1;
            next_dre = 1'b0;
        end
        if (RX_CHECK_VALID) begin
            next_perr = par_en && ((^rx_masked) ^ PARITY_SELECT[0] ^ RX_CHECK_PARITY);
        end
        next_txd = (next_state == UCT_ACTIVE && next_primed) ? next_frame[next_idx] : `UCT_IDLE_LEVEL;
        next_xck = next_level ^ PIN_INVERSION_ENABLE;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= UCT_IDLE;
            frame <= 13'h1FFF;
            idx <= 4'h0;
            last <= 4'h0;
            smp <= 4'h0;
            primed <= 1'b0;
            level <= `UCT_RST_CLOCK_LEVEL;
            clk_prev <= 1'b0;
            buf_data <= 9'h000;
            buf_full <= 1'b0;
            BUFFER_EMPTY_FLAG <= `UCT_RST_BUFFER_EMPTY;
            TRANSMIT_COMPLETE_FLAG <= `UCT_RST_TX_COMPLETE;
            TXD_OUT <= `UCT_IDLE_LEVEL;
            TRANSFER_CLOCK_PIN_OUT <= `UCT_RST_CLOCK_LEVEL;
            RX_SAMPLE_STROBE <= 1'b0;
            PARITY_ERROR_FLAG <= 1'b0;
        end else begin
            state <= next_state;
            frame <= next_frame;
            idx <= next_idx;
            last <= next_last;
            smp <= next_smp;
            primed <= next_primed;
            level <= next_level;
            clk_prev <= next_clk_prev;
            buf_data <= next_buf_data;
            buf_full <= next_buf_full;
            BUFFER_EMPTY_FLAG <= next_dre;
            TRANSMIT_COMPLETE_FLAG <= next_txc;
            TXD_OUT <= next_txd;
            TRANSFER_CLOCK_PIN_OUT <= next_xck;
            RX_SAMPLE_STROBE <= next_strobe;
            PARITY_ERROR_FLAG <= next_perr;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    idle_line_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        state == UCT_IDLE |-> TXD_OUT == 1'b1)
        else $error("line not high while idle");
    start_bit_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (state == UCT_ACTIVE && is_async && idx == 4'h0) |-> TXD_OUT == 1'b0)
        else $error("start bit not low");
    empty_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        TRANSMIT_BUFFER_WRITE |=> !BUFFER_EMPTY_FLAG)
        else $error("empty flag not cleared by write");
    empty_set_load_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (load && !TRANSMIT_BUFFER_WRITE) |=> BUFFER_EMPTY_FLAG && state == UCT_ACTIVE)
        else $error("load did not set empty flag");
    complete_set_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (finish && !buf_full) |=> TRANSMIT_COMPLETE_FLAG && state == UCT_IDLE)
        else $error("complete flag missed");
    back_to_back_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (finish && buf_full) |=> state == UCT_ACTIVE && idx == 4'h0 && !$rose(TRANSMIT_COMPLETE_FLAG))
        else $error("pending frame not started at once");
    spi_eight_bits_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (load && is_spi) |=> last == 4'h7)
        else $error("spi frame not eight bits");
    opposite_edges_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !(lead && trail))
        else $error("change and sample on one edge");
    async_sample_rate_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (state == UCT_ACTIVE && is_async) |-> smp <= (DOUBLE_SPEED_SETTING ? 4'h7 : 4'hF))
        else $error("sample count out of range");
    master_clock_dir_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (!is_async && !is_slave && $stable(PIN_INVERSION_ENABLE)) |->
        !TRANSFER_CLOCK_PIN_OE_B ##1 ($stable(TRANSFER_CLOCK_PIN_OUT) || $past(tick)))
        else $error("master clock pin not driven");
    parity_error_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (RX_CHECK_VALID && !par_en) |=> !PARITY_ERROR_FLAG)
        else $error("parity error without parity");
endmodule
`default_nettype wire
